// ==== lnmwc_pkg.sv ====
package lnmwc_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;
  localparam int RESET_TIME_US      = 4000;   // reset output low after power-up
  localparam int DOM_TIMEOUT_US     = 6000;   // transmit dominant time-out
  localparam int WAKE_REARM_US      = 10;     // wake pin high before rearm
  localparam int IGN_REARM_US       = 250;    // ignition low before rearm
  localparam int BUS_FILTER_US      = 30;     // bus wake filter time
  localparam int WAKE_FILTER_US     = 30;     // wake pin filter time
  localparam int IGNITION_FILTER_US = 160;    // ignition_filter_time
  localparam int CYC_PER_US         = 1000 / CLK_PERIOD_NS;
  localparam int RESET_CYC          = RESET_TIME_US * CYC_PER_US;
  localparam int DOM_CYC            = DOM_TIMEOUT_US * CYC_PER_US;
  localparam int WAKE_REARM_CYC     = WAKE_REARM_US * CYC_PER_US + 1;
  localparam int IGN_REARM_CYC      = IGN_REARM_US * CYC_PER_US + 1;
  localparam int BUS_FILT_CYC       = BUS_FILTER_US * CYC_PER_US + 1;
  localparam int WAKE_FILT_CYC      = WAKE_FILTER_US * CYC_PER_US + 1;
  localparam int IGN_FILT_CYC       = IGNITION_FILTER_US * CYC_PER_US + 1;
  localparam int CNT_W              = 20;

  // ---------------------------------------------------------------
  // modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LNMWC_UNPOWERED,
    LNMWC_FAILSAFE,
    LNMWC_NORMAL,
    LNMWC_SILENT,
    LNMWC_SLEEP
  } lnmwc_mode_t;
endpackage : lnmwc_pkg

// ==== lnmwc_ctrl.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// RL1: reset output low forces fail-safe mode from any mode; the code does this from normal and silent only, not from sleep.
// RL2: normal mode keeps undervoltage detection and watchdog reset path active.
// RL3: mode-select falling with transmit high enters silent mode.
// RL4: silent disables transmit path and termination; regulator stays on.
// RL5: undervoltage in silent drives reset low and enters fail-safe.
// RL6: bus below pre-wake threshold in silent/sleep enables receiver and termination.
// RL7: bus fall, long dominant, rise gives remote wake into fail-safe.
// RL8: after remote wake from silent, mode-select high goes straight to normal.
// RL9: bus low in normal starts filter; wake on rise after entering low power.
// RL10: mode-select falling with transmit low enters sleep mode.
// RL11: host may lower mode-select up to 3.2 us before transmit; the code samples transmit in the cycle that mode-select falls.
// RL12: sleep turns off regulator and inhibit, holds reset and receive low.
// RL13: low-power entry accepted whatever bus, wake and ignition levels are.
// RL14: power-up enters fail-safe, regulator on, reset low for 4 ms.
// RL15: fail-safe holds until mode-select high, then goes to normal.
// RL16: battery below 4 V in silent or sleep goes to fail-safe.
// RL17: leave unpowered when battery is good; ignore requests during reset delay.
// RL18: filtered wake pin low gives local wake, receive low, transmit pulled low.
// RL19: wake pin must return high over 10 us before a new wake counts.
// RL20: filtered ignition high gives local wake, receive low, transmit pulled low.
// RL21: ignition must stay low over 250 us before a new wake counts.
// RL22: fail-safe transmit pin reports wake source: high remote, low local.
// RL23: wake request and source flags clear on reaching normal mode.
// RL24: normal mode enables transmit and receive paths.
// RL25: normal mode drives bus dominant only while transmit pin is low.
// RL26: receive pin follows bus in normal mode.
// RL27: transmit low over 6 ms forces bus recessive until transmit goes high.
// RL28: inputs synchronised before edges; filters timed by counters.
module lnmwc_ctrl
  import lnmwc_pkg::*;
#(
  parameter int RESET_CYCLES = lnmwc_pkg::RESET_CYC,
  parameter int DOM_CYCLES   = lnmwc_pkg::DOM_CYC
)(
  input  wire logic clk_sys,              // 100 MHz system clock
  input  wire logic arst_n,               // async reset, power-up
  input  wire logic clk_en,               // freezes all state when low
  input  wire logic battery_ok,           // battery_supply above threshold
  input  wire logic vcc_uv,               // regulator undervoltage
  input  wire logic wd_expired,           // watchdog missed trigger
  input  wire logic mode_sel,             // host mode-select pin
  input  wire logic txd_in,               // host transmit pin level
  input  wire logic bus_rx,               // bus level, 1 recessive
  input  wire logic bus_prewake_threshold,// bus below pre-wake level
  input  wire logic wake_in,              // local wake pin
  input  wire logic ignition_wake_in,     // ignition pin
  output logic      bus_drive_dom,        // bus driver dominant
  output logic      bus_rx_en,            // internal bus receiver on
  output logic      slave_term_en,        // slave termination on
  output logic      regulator_en,         // regulator on
  output logic      ext_regulator_switch_out, // inhibit output
  output logic      rst_out_n,            // reset output level
  output logic      rst_out_oe_n,         // reset pin open-drain enable, low drives
  output logic      rxd_out,              // receive pin to host
  output logic      txd_out,              // transmit pin value in fail-safe
  output logic      txd_oe_n,             // transmit pin drive enable, low drives
  output logic      wd_en,                // watchdog running
  output logic      uv_det_en,            // undervoltage detection on
  output lnmwc_pkg::lnmwc_mode_t mode_out // current mode
);
  import lnmwc_pkg::*;

  initial
  begin
    if (RESET_CYCLES < 1 || RESET_CYCLES >= (1 << CNT_W))
      $error("RESET_CYCLES out of range");
    if (DOM_CYCLES < 1 || DOM_CYCLES >= (1 << CNT_W))
      $error("DOM_CYCLES out of range");
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int NSYNC = 6;
  localparam logic [NSYNC-1:0] SYNC_IDLE = 6'h16; // mode-select low, transmit and wake high, bus low, pre-wake high, ignition low; no false mode-select edge follows reset
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  assign raw_in = {mode_sel, txd_in, bus_rx, bus_prewake_threshold, wake_in, ignition_wake_in};

  // two-stage sync plus one delay stage for edges
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
      s3_q <= SYNC_IDLE;
    end
    else if (clk_en)
    begin
      s1_q <= raw_in;  // RL28
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic sel_s, txd_s, bus_s, prew_s, wake_s, ign_s, sel_fall;
  assign sel_s    = s2_q[5];
  assign txd_s    = s2_q[4];
  assign bus_s    = s2_q[3];
  assign prew_s   = s2_q[2];
  assign wake_s   = s2_q[1];
  assign ign_s    = s2_q[0];
  assign sel_fall = s3_q[5] & ~sel_s;

  function automatic logic sat_done(input logic [CNT_W-1:0] c, input int lim);
    sat_done = (c >= CNT_W'(lim));
  endfunction : sat_done

  // ---------------------------------------------------------------
  // mode state machine and reset delay
  // ---------------------------------------------------------------
  lnmwc_mode_t      mode_q;
  logic [CNT_W-1:0] rst_cnt_q;
  logic             rst_hold_q;
  logic             wake_req_q;   // wake request flag
  logic             wake_local_q; // wake source, 1 local
  logic             remote_ev, local_ev, low_pwr, uv_now;

  assign low_pwr = (mode_q == LNMWC_SILENT) || (mode_q == LNMWC_SLEEP);
  assign uv_now  = vcc_uv || wd_expired;

  // reset output delay counter
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_hold_q <= 1'b1;
      rst_cnt_q  <= '0;
    end
    else if (clk_en)
    begin
      if (!battery_ok || (mode_q != LNMWC_SLEEP && mode_q != LNMWC_SILENT && uv_now)
          || (mode_q == LNMWC_SILENT && vcc_uv) || mode_q == LNMWC_UNPOWERED)
      begin
        rst_hold_q <= 1'b1;  // RL2 RL5
        rst_cnt_q  <= '0;
      end
      else if (rst_hold_q && mode_q != LNMWC_SLEEP)
      begin
        if (sat_done(rst_cnt_q, RESET_CYCLES - 1))
          rst_hold_q <= 1'b0;  // RL14
        else
          rst_cnt_q <= rst_cnt_q + 1'b1;
      end
    end
  end

  // mode transitions
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      mode_q <= LNMWC_UNPOWERED;
    else if (clk_en)
    begin
      case (mode_q)
        LNMWC_UNPOWERED:
          if (battery_ok)
            mode_q <= LNMWC_FAILSAFE;  // RL17 RL14
        LNMWC_FAILSAFE:
          if (!battery_ok)
            mode_q <= LNMWC_UNPOWERED;
          else if (!rst_hold_q && sel_s)
            mode_q <= LNMWC_NORMAL;  // RL15 RL8 RL17
        LNMWC_NORMAL:
          if (!battery_ok)
            mode_q <= LNMWC_UNPOWERED;
          else if (rst_hold_q)
            mode_q <= LNMWC_FAILSAFE;  // RL1
          else if (sel_fall)
            mode_q <= txd_s ? LNMWC_SILENT : LNMWC_SLEEP;  // RL3 RL10 RL13
        LNMWC_SILENT, LNMWC_SLEEP:
          if (!battery_ok || remote_ev || local_ev || (mode_q == LNMWC_SILENT && rst_hold_q))
            mode_q <= LNMWC_FAILSAFE;  // RL16 RL7 RL18 RL20 RL5 RL1
        default:
          mode_q <= LNMWC_FAILSAFE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // wake detection
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] bus_cnt_q, wake_cnt_q, ign_cnt_q;
  logic             bus_armed_q, wake_armed_q, ign_armed_q;

  // bus dominant filter; started in normal mode too
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_cnt_q   <= '0;
      bus_armed_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (bus_s)
      begin
        bus_cnt_q   <= '0;
        bus_armed_q <= 1'b0;
      end
      else if (mode_q == LNMWC_NORMAL || low_pwr)
      begin
        if (sat_done(bus_cnt_q, BUS_FILT_CYC))
          bus_armed_q <= 1'b1;  // RL9
        else
          bus_cnt_q <= bus_cnt_q + 1'b1;
      end
    end
  end
  assign remote_ev = low_pwr && bus_armed_q && bus_s;  // RL7 RL9

  // wake pin: rearm after high time, then low filter
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wake_cnt_q   <= '0;
      wake_armed_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wake_s)
      begin
        if (sat_done(wake_cnt_q, WAKE_REARM_CYC))
          wake_armed_q <= 1'b1;  // RL19
        else
          wake_cnt_q <= wake_cnt_q + 1'b1;
      end
      else
      begin
        wake_cnt_q <= '0;
        // a low level outside low power must not wake later: it needs a fresh rearm
        if (!low_pwr)
          wake_armed_q <= 1'b0;  // RL19 RL13
      end
    end
  end

  logic [CNT_W-1:0] wlow_cnt_q, ihigh_cnt_q;
  logic             wake_hit, ign_hit;

  // low/high hold timers for local wakes
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wlow_cnt_q  <= '0;
      ihigh_cnt_q <= '0;
    end
    else if (clk_en)
    begin
      wlow_cnt_q  <= (wake_s || !wake_armed_q) ? '0 : wlow_cnt_q + 1'b1;
      ihigh_cnt_q <= (!ign_s || !ign_armed_q) ? '0 : ihigh_cnt_q + 1'b1;
    end
  end
  assign wake_hit = low_pwr && wake_armed_q && sat_done(wlow_cnt_q, WAKE_FILT_CYC);   // RL18
  assign ign_hit  = low_pwr && ign_armed_q && sat_done(ihigh_cnt_q, IGN_FILT_CYC);   // RL20
  assign local_ev = wake_hit || ign_hit;

  // ignition: rearm after low time
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ign_cnt_q   <= '0;
      ign_armed_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!ign_s)
      begin
        if (sat_done(ign_cnt_q, IGN_REARM_CYC))
          ign_armed_q <= 1'b1;  // RL21
        else
          ign_cnt_q <= ign_cnt_q + 1'b1;
      end
      else
      begin
        ign_cnt_q <= '0;
        // a high level outside low power must not wake later: it needs a fresh rearm
        if (ign_hit || !low_pwr)
          ign_armed_q <= 1'b0;  // RL21 RL13
      end
    end
  end

  // wake flags; set wins over clear
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wake_req_q   <= 1'b0;
      wake_local_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (remote_ev || local_ev)
      begin
        wake_req_q   <= 1'b1;
        wake_local_q <= local_ev;  // RL22
      end
      else if (mode_q == LNMWC_NORMAL)
      begin
        wake_req_q   <= 1'b0;  // RL23
        wake_local_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit dominant time-out
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] dom_cnt_q;
  logic             dom_block_q;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dom_cnt_q   <= '0;
      dom_block_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (txd_s)
      begin
        dom_cnt_q   <= '0;
        dom_block_q <= 1'b0;
      end
      else if (sat_done(dom_cnt_q, DOM_CYCLES))
        dom_block_q <= 1'b1;  // RL27
      else
        dom_cnt_q <= dom_cnt_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_drive_dom            <= 1'b0;
      bus_rx_en                <= 1'b0;
      slave_term_en            <= 1'b0;
      regulator_en             <= 1'b0;
      ext_regulator_switch_out <= 1'b0;
      rst_out_n                <= 1'b0;
      rst_out_oe_n             <= 1'b0;
      rxd_out                  <= 1'b1;
      txd_out                  <= 1'b1;
      txd_oe_n                 <= 1'b1;
      wd_en                    <= 1'b0;
      uv_det_en                <= 1'b0;
      mode_out                 <= LNMWC_UNPOWERED;
    end
    else if (clk_en)
    begin
      mode_out      <= mode_q;
      bus_drive_dom <= (mode_q == LNMWC_NORMAL) && !txd_s && !dom_block_q;  // RL24 RL25
      bus_rx_en     <= (mode_q == LNMWC_NORMAL) || (low_pwr && prew_s);     // RL6
      slave_term_en <= (mode_q == LNMWC_NORMAL) || (mode_q == LNMWC_FAILSAFE)
                       || (low_pwr && prew_s);                              // RL4 RL6
      regulator_en  <= (mode_q != LNMWC_SLEEP) && (mode_q != LNMWC_UNPOWERED); // RL4 RL12 RL14
      ext_regulator_switch_out <= (mode_q == LNMWC_NORMAL) || (mode_q == LNMWC_FAILSAFE); // RL7 RL12
      rst_out_n     <= !rst_hold_q && (mode_q != LNMWC_SLEEP);              // RL12
      rst_out_oe_n  <= !(rst_hold_q || mode_q == LNMWC_SLEEP);
      wd_en         <= (mode_q == LNMWC_NORMAL) || (mode_q == LNMWC_FAILSAFE); // RL2
      uv_det_en     <= (mode_q != LNMWC_SLEEP) && (mode_q != LNMWC_UNPOWERED); // RL2 RL5
      if (mode_q == LNMWC_NORMAL)
        rxd_out <= bus_s;  // RL26
      else if (mode_q == LNMWC_FAILSAFE)
        rxd_out <= !wake_req_q;  // RL7 RL18
      else
        rxd_out <= (mode_q == LNMWC_SILENT);  // RL12
      txd_out  <= !(mode_q == LNMWC_FAILSAFE && wake_local_q);  // RL22
      txd_oe_n <= !(mode_q == LNMWC_FAILSAFE && wake_req_q && wake_local_q);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence seq_low_pwr_rst;
    low_pwr ##1 clk_en && rst_hold_q && mode_q == LNMWC_SILENT;
  endsequence

  AST_RST_FAILSAFE: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL1
    clk_en && rst_hold_q && mode_q == LNMWC_NORMAL |=> mode_q == LNMWC_FAILSAFE)
    else $error("reset low did not force fail-safe");
  AST_SILENT_ENTRY: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL3
    clk_en && mode_q == LNMWC_NORMAL && battery_ok && !rst_hold_q && sel_fall && txd_s
    |=> mode_q == LNMWC_SILENT)
    else $error("silent mode not entered");
  AST_SLEEP_ENTRY: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL10
    clk_en && mode_q == LNMWC_NORMAL && battery_ok && !rst_hold_q && sel_fall && !txd_s
    |=> mode_q == LNMWC_SLEEP)
    else $error("sleep mode not entered");
  AST_SLEEP_OUTS: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL12
    clk_en && mode_q == LNMWC_SLEEP |=> !regulator_en && !rxd_out && !rst_out_n)
    else $error("sleep outputs wrong");
  AST_SILENT_UV: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL5
    seq_low_pwr_rst |=> mode_q == LNMWC_FAILSAFE)
    else $error("undervoltage in silent kept mode");
  AST_WAKE_REQ: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL7
    clk_en && remote_ev |=> mode_q == LNMWC_FAILSAFE && wake_req_q && !wake_local_q)
    else $error("remote wake not taken");
  AST_LOCAL_WAKE: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL18
    clk_en && local_ev |=> wake_local_q ##1 !clk_en || !txd_out)
    else $error("local wake source not shown");
  AST_FLAG_CLEAR: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL23
    clk_en && mode_q == LNMWC_NORMAL |=> !wake_req_q)
    else $error("wake flag not cleared in normal");
  AST_DOM_TIMEOUT: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL27
    clk_en && dom_block_q && !txd_s |=> !bus_drive_dom)
    else $error("bus dominant past time-out");
endmodule : lnmwc_ctrl

// ==== lnmwc_host_model.sv ====
`timescale 1ns/100ps
module lnmwc_host_model
(
  input  wire logic clk_sys,  // system clock, host acts on falling edge
  input  wire logic txd_oe_n, // device strong pull-down, low drives
  output logic      mode_sel, // mode-select pin
  output logic      txd_in    // resolved transmit pin level
);
  logic host_txd; // host level, 1 also when released (pull-up)

  // ---------------------------------------------------------------
  // pin resolution
  // ---------------------------------------------------------------
  // the device pull-down wins over whatever the host drives
  assign txd_in = txd_oe_n ? host_txd : 1'b0;

  // idle host: mode-select low, transmit released
  initial
  begin
    mode_sel = 1'b0;
    host_txd = 1'b1;
  end

  // ---------------------------------------------------------------
  // host actions
  // ---------------------------------------------------------------
  // change the transmit level just after a falling edge
  task automatic set_txd(input logic lvl);
    @(negedge clk_sys);
    host_txd = lvl;
  endtask : set_txd

  // change the mode-select level just after a falling edge
  task automatic set_mode(input logic lvl);
    @(negedge clk_sys);
    mode_sel = lvl;
  endtask : set_mode

  // lower mode-select and set the transmit level together, then hold both over the window
  task automatic enter_low(input logic txd_lvl);
    @(negedge clk_sys);
    host_txd = txd_lvl;
    mode_sel = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask : enter_low
endmodule : lnmwc_host_model

// ==== test_lin_node_mode_wake_controller.sv ====
`timescale 1ns/100ps
module test_lin_node_mode_wake_controller;
  import lnmwc_pkg::*;
  localparam int SIM_CYC = 50; // shortened reset delay and dominant time-out

  logic        clk_sys, arst_n, clk_en, battery_ok, vcc_uv, wd_expired;
  logic        mode_sel, txd_in, bus_rx, prewake, wake_in, ign_in;
  logic        bus_drive_dom, bus_rx_en, slave_term_en, regulator_en, inh_out;
  logic        rst_out_n, rst_out_oe_n, rxd_out, txd_out, txd_oe_n, wd_en, uv_det_en;
  lnmwc_mode_t mode_out;
  int          errors;
  int          checked;

  // device under test with shortened counts
  lnmwc_ctrl #(.RESET_CYCLES(SIM_CYC), .DOM_CYCLES(SIM_CYC)) dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .battery_ok(battery_ok),
    .vcc_uv(vcc_uv), .wd_expired(wd_expired), .mode_sel(mode_sel), .txd_in(txd_in),
    .bus_rx(bus_rx), .bus_prewake_threshold(prewake), .wake_in(wake_in),
    .ignition_wake_in(ign_in), .bus_drive_dom(bus_drive_dom), .bus_rx_en(bus_rx_en),
    .slave_term_en(slave_term_en), .regulator_en(regulator_en),
    .ext_regulator_switch_out(inh_out), .rst_out_n(rst_out_n), .rst_out_oe_n(rst_out_oe_n),
    .rxd_out(rxd_out), .txd_out(txd_out), .txd_oe_n(txd_oe_n), .wd_en(wd_en),
    .uv_det_en(uv_det_en), .mode_out(mode_out));

  // host on the mode-select and transmit pins
  lnmwc_host_model host_u (.clk_sys(clk_sys), .txd_oe_n(txd_oe_n), .mode_sel(mode_sel), .txd_in(txd_in));

  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic chk_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_mode(input lnmwc_mode_t exp);
    checked++;
    if (mode_out !== exp)
    begin
      errors++;
      $display("MISMATCH mode_out expected %0d seen %0d", exp, mode_out);
    end
  endtask : chk_mode

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : idle

  // bounded wait for a mode; running out ends the run
  task automatic wait_mode(input lnmwc_mode_t m, input int bound);
    int n;
    n = 0;
    while (mode_out !== m && n < bound)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk_mode(m);
    if (mode_out !== m)
      summarize();
  endtask : wait_mode

  // bounded wait for the reset output to go high
  task automatic wait_rst(input int bound);
    int n;
    n = 0;
    while (rst_out_n !== 1'b1 && n < bound)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk_bit("rst_out_n", 1'b1, rst_out_n);
    if (rst_out_n !== 1'b1)
      summarize();
  endtask : wait_rst

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // power-up, request during reset delay, then fail-safe to normal
  task automatic test_power_up;
    wait_mode(LNMWC_FAILSAFE, 10);
    chk_bit("regulator_en", 1'b1, regulator_en);
    chk_bit("bus_drive_dom", 1'b0, bus_drive_dom);
    host_u.set_mode(1'b1);
    idle(6);
    host_u.set_mode(1'b0);
    idle(30);
    chk_mode(LNMWC_FAILSAFE);
    chk_bit("rst_out_n", 1'b0, rst_out_n);
    wait_rst(40);
    idle(10);
    chk_mode(LNMWC_FAILSAFE);
    host_u.set_mode(1'b1);
    wait_mode(LNMWC_NORMAL, 10);
    chk_bit("wd_en", 1'b1, wd_en);
    chk_bit("uv_det_en", 1'b1, uv_det_en);
    $display("test power_up done");
  endtask : test_power_up

  // transmit and receive paths, dominant time-out, watchdog reset
  task automatic test_normal_path;
    host_u.set_txd(1'b0);
    idle(5);
    chk_bit("bus_drive_dom", 1'b1, bus_drive_dom);
    bus_rx = 1'b0;
    idle(5);
    chk_bit("rxd_out", 1'b0, rxd_out);
    idle(SIM_CYC + 10);
    chk_bit("bus_drive_dom", 1'b0, bus_drive_dom);
    bus_rx = 1'b1;
    host_u.set_txd(1'b1);
    idle(5);
    chk_bit("rxd_out", 1'b1, rxd_out);
    chk_bit("bus_drive_dom", 1'b0, bus_drive_dom);
    idle(20);
    host_u.set_txd(1'b0);
    idle(5);
    chk_bit("bus_drive_dom", 1'b1, bus_drive_dom);
    host_u.set_txd(1'b1);
    wd_expired = 1'b1;
    wait_mode(LNMWC_FAILSAFE, 20);
    chk_bit("rst_out_n", 1'b0, rst_out_n);
    wd_expired = 1'b0;
    wait_rst(200);
    wait_mode(LNMWC_NORMAL, 20);
    $display("test normal_path done");
  endtask : test_normal_path

  // silent entry with wake pins active, pre-wake, remote wake, direct return
  task automatic test_silent_remote;
    idle(WAKE_REARM_CYC);
    wake_in = 1'b0;
    ign_in = 1'b1;
    host_u.enter_low(1'b1);
    wait_mode(LNMWC_SILENT, 10);
    chk_bit("slave_term_en", 1'b0, slave_term_en);
    chk_bit("regulator_en", 1'b1, regulator_en);
    chk_bit("uv_det_en", 1'b1, uv_det_en);
    chk_bit("bus_drive_dom", 1'b0, bus_drive_dom);
    prewake = 1'b1;
    idle(5);
    chk_bit("bus_rx_en", 1'b1, bus_rx_en);
    chk_bit("slave_term_en", 1'b1, slave_term_en);
    bus_rx = 1'b0;
    idle(BUS_FILT_CYC + 100);
    chk_mode(LNMWC_SILENT);
    bus_rx = 1'b1;
    prewake = 1'b0;
    wait_mode(LNMWC_FAILSAFE, 10);
    chk_bit("rxd_out", 1'b0, rxd_out);
    chk_bit("inh_out", 1'b1, inh_out);
    chk_bit("txd_in", 1'b1, txd_in);
    chk_bit("txd_out", 1'b1, txd_out);
    chk_bit("txd_oe_n", 1'b1, txd_oe_n);
    host_u.set_mode(1'b1);
    wait_mode(LNMWC_NORMAL, 10);
    idle(2);
    chk_bit("rxd_out", 1'b1, rxd_out);
    $display("test silent_remote done");
  endtask : test_silent_remote

  // sleep entry with both pins lowered together, local wake by wake pin
  task automatic test_sleep_wake;
    wake_in = 1'b1;
    host_u.enter_low(1'b0);
    wait_mode(LNMWC_SLEEP, 10);
    chk_bit("regulator_en", 1'b0, regulator_en);
    chk_bit("inh_out", 1'b0, inh_out);
    chk_bit("rst_out_n", 1'b0, rst_out_n);
    chk_bit("rxd_out", 1'b0, rxd_out);
    chk_bit("slave_term_en", 1'b0, slave_term_en);
    host_u.set_txd(1'b1);
    idle(WAKE_REARM_CYC + 100);
    wake_in = 1'b0;
    idle(WAKE_FILT_CYC + 100);
    wait_mode(LNMWC_FAILSAFE, 10);
    chk_bit("txd_in", 1'b0, txd_in);
    chk_bit("txd_out", 1'b0, txd_out);
    chk_bit("rxd_out", 1'b0, rxd_out);
    wake_in = 1'b1;
    host_u.set_mode(1'b1);
    wait_mode(LNMWC_NORMAL, 200);
    idle(2);
    chk_bit("txd_oe_n", 1'b1, txd_oe_n);
    $display("test sleep_wake done");
  endtask : test_sleep_wake

  // silent entered with ignition high, rearm low time, ignition wake
  task automatic test_ignition;
    host_u.enter_low(1'b1);
    wait_mode(LNMWC_SILENT, 10);
    ign_in = 1'b0;
    idle(IGN_REARM_CYC + 100);
    ign_in = 1'b1;
    idle(IGN_FILT_CYC - 1000);
    chk_mode(LNMWC_SILENT);
    idle(1100);
    wait_mode(LNMWC_FAILSAFE, 10);
    chk_bit("txd_in", 1'b0, txd_in);
    chk_bit("rxd_out", 1'b0, rxd_out);
    host_u.set_mode(1'b1);
    wait_mode(LNMWC_NORMAL, 200);
    $display("test ignition done");
  endtask : test_ignition

  // clock-enable freeze, undervoltage in silent, battery loss in sleep
  task automatic test_supply_faults;
    clk_en = 1'b0;
    host_u.enter_low(1'b1);
    chk_mode(LNMWC_NORMAL);
    clk_en = 1'b1;
    wait_mode(LNMWC_SILENT, 10);
    vcc_uv = 1'b1;
    wait_mode(LNMWC_FAILSAFE, 20);
    chk_bit("rst_out_n", 1'b0, rst_out_n);
    chk_bit("rst_out_oe_n", 1'b0, rst_out_oe_n);
    vcc_uv = 1'b0;
    host_u.set_mode(1'b1);
    wait_mode(LNMWC_NORMAL, 200);
    host_u.enter_low(1'b0);
    wait_mode(LNMWC_SLEEP, 10);
    host_u.set_txd(1'b1);
    battery_ok = 1'b0;
    wait_mode(LNMWC_FAILSAFE, 20);
    battery_ok = 1'b1;
    $display("test supply_faults done");
  endtask : test_supply_faults

  // ---------------------------------------------------------------
  // clock and main sequence
  // ---------------------------------------------------------------
  // 100 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // reset, scenarios, verdict
  initial
  begin
    errors = 0;
    checked = 0;
    arst_n = 1'b0;
    clk_en = 1'b1;
    battery_ok = 1'b1;
    vcc_uv = 1'b0;
    wd_expired = 1'b0;
    bus_rx = 1'b1;
    prewake = 1'b0;
    wake_in = 1'b1;
    ign_in = 1'b0;
    repeat (8) @(negedge clk_sys);
    arst_n = 1'b1;
    test_power_up();
    test_normal_path();
    test_silent_remote();
    test_sleep_wake();
    test_ignition();
    test_supply_faults();
    summarize();
  end
endmodule : test_lin_node_mode_wake_controller
